// ===== design/pms_pkg.sv
// ==========================================================
// shared constants for the power meter status map
// ==========================================================
package pms_pkg;

  // ==========================================================
  // measurand identifiers
  // ==========================================================
  localparam logic [5:0] ID_E_CONS = 6'h01; // consumer active energy
  localparam logic [5:0] ID_E_PROD = 6'h02; // producer active energy
  localparam logic [5:0] ID_FREQ = 6'h0c; // frequency, 16 bit
  localparam logic [5:0] ID_TEMP = 6'h0e; // temperature, 16 bit
  localparam logic [5:0] ID_V_L1 = 6'h12; // voltage l1
  localparam logic [5:0] ID_I_L1 = 6'h13; // current l1
  localparam logic [5:0] ID_PF_L1 = 6'h14; // cos phi l1
  localparam logic [5:0] ID_PH_STEP = 6'h08; // id distance between phases
  localparam logic [5:0] ID_OVF_CONS = 6'h27; // overflow of consumer counter
  localparam logic [5:0] ID_OVF_PROD = 6'h28; // overflow of producer counter
  localparam logic [5:0] ID_STATUS = 6'h29; // limit status word

  // ==========================================================
  // command codes and status word layout
  // ==========================================================
  localparam logic [7:0] CMD_ACK = 8'h04; // acknowledge limit status
  localparam logic [15:0] STATUS_RST = 16'h0100; // byte 1 bit 0 flags a reset
  localparam int BIT_TEMP_HI = 5; // temperature above limit
  localparam int BIT_FREQ_LO = 6; // frequency below limit
  localparam int BIT_TEMP_HI2 = 7; // second temperature flag
  localparam int BIT_RESET = 8; // module reset seen
  localparam int BIT_VLO [3] = '{15, 0, 1}; // voltage low, l1..l3
  localparam int BIT_VHI [3] = '{2, 3, 4}; // voltage high, l1..l3
  localparam int BIT_IHI [3] = '{9, 10, 11}; // current high, l1..l3
  localparam int BIT_PFLO [3] = '{12, 13, 14}; // power factor low, l1..l3

  // ==========================================================
  // dataset tag range and read framing
  // ==========================================================
  localparam logic [3:0] TAG_MIN = 4'h1; // first tag value
  localparam logic [3:0] TAG_MAX = 4'hf; // last tag before wrap
  localparam logic [2:0] LEN_NONE = 3'h0; // id not served

  // byte count of a measurand, zero for ids not served
  function automatic logic [2:0] id_len(input logic [5:0] id);
    logic [2:0] len;
    len = LEN_NONE;
    unique case (id)
      ID_E_CONS, ID_E_PROD, ID_OVF_CONS, ID_OVF_PROD: len = 3'h4;
      ID_V_L1, ID_V_L1 + ID_PH_STEP, ID_V_L1 + 6'h10: len = 3'h4;
      ID_I_L1, ID_I_L1 + ID_PH_STEP, ID_I_L1 + 6'h10: len = 3'h2;
      ID_PF_L1, ID_PF_L1 + ID_PH_STEP, ID_PF_L1 + 6'h10: len = 3'h1;
      ID_FREQ, ID_TEMP, ID_STATUS: len = 3'h2;
      default: len = LEN_NONE;
    endcase
    return len;
  endfunction : id_len

endpackage : pms_pkg

// ===== design/pms_energy_acc.sv
`timescale 1ns/1ps
// ==========================================================
// energy counter with ratio prescaler and overflow count
// ==========================================================
module pms_energy_acc (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // energy input
  input wire logic step_i, // one pulse per metered watt-hour
  input wire logic [15:0] ratio_i, // transformer ratio, zero acts as one
  // results
  output logic [31:0] count_o, // scaled energy count
  output logic [31:0] ovf_o, // number of counter wraps
  output logic wrap_o // pulse, counter just wrapped
);

  // all state in one record
  typedef struct packed {
    logic [15:0] pre; // watt-hours since last count step
    logic [31:0] cnt; // energy count
    logic [31:0] ovf; // overflow count
    logic wrap; // wrap pulse
  } pms_acc_st_t;

  pms_acc_st_t st_r;
  pms_acc_st_t st_nxt;
  logic step_due; // prescaler reached the ratio

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    st_nxt = st_r;
    st_nxt.wrap = 1'b0;
    // a ratio of zero would never step, so treat it as one
    step_due = step_i && (st_r.pre + 16'h0001 >= ratio_i);
    if (step_i) begin
      st_nxt.pre = step_due ? 16'h0000 : st_r.pre + 16'h0001;
    end
    if (step_due) begin
      st_nxt.cnt = st_r.cnt + 32'h0000_0001;
      if (st_r.cnt == 32'hffff_ffff) begin
        st_nxt.ovf = st_r.ovf + 32'h0000_0001;
        st_nxt.wrap = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count_o = st_r.cnt;
  assign ovf_o = st_r.ovf;
  assign wrap_o = st_r.wrap;

  // ==========================================================
  // checks
  // ==========================================================
  a_ovf_on_wrap: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_r.cnt == 32'hffff_ffff && step_due) |=> (ovf_o == $past(ovf_o) + 32'h1) && wrap_o)
    else $error("overflow count missed a wrap");
  a_ovf_stable: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !wrap_o |-> ovf_o == $past(ovf_o))
    else $error("overflow count moved without a wrap");

endmodule : pms_energy_acc

// ===== design/pms_status_map.sv
`timescale 1ns/1ps
// Function
// - two overflow counters count energy counter wraps
// - energy step equals one Wh times ratio
// - requester picks measured value by identifier
// - sixteen bit limit status readable as measurand
// - limits come from written parameter set
// - status updates when dataset tag advances
// - status bits stick until acknowledge command
// - status word sent high byte first
// - one means active, zero inactive
// - byte0 bits0-1: L2, L3 voltage low
// - byte0 bits2-4: L1-L3 voltage high
// - bit5 temp high, bit6 freq low, bit7 temp
// - byte1 bit0 set by every reset
// - command 0x04 clears byte1 bit0
// - byte1 bits1-3: L1-L3 current high
// - byte1 bits4-6: L1-L3 power factor low
// - byte1 bit7: L1 voltage low
// - dataset tag is four bits, 1 to 15
// - energy counter is 32 bit, wrap counted
module pms_status_map (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // new coherent measurement set
  input wire logic refresh_i, // pulse, a new data set is ready
  input wire logic [2:0][31:0] vrms_i, // rms voltage per phase, mV
  input wire logic [2:0][15:0] irms_i, // rms current per phase, mA
  input wire logic signed [2:0][7:0] pf_i, // cos phi per phase, 0.01
  input wire logic signed [15:0] temp_i, // temperature, 0.01 C
  input wire logic [15:0] freq_i, // frequency, 0.01 Hz
  input wire logic cons_wh_i, // pulse per consumed Wh
  input wire logic prod_wh_i, // pulse per produced Wh
  // parameter set from the controlling party
  input wire logic [31:0] rms_voltage_low_limit_i,
  input wire logic [31:0] rms_voltage_high_limit_i,
  input wire logic [15:0] rms_current_high_limit_i,
  input wire logic signed [7:0] power_factor_low_limit_i,
  input wire logic signed [15:0] temperature_high_limit_i,
  input wire logic [15:0] frequency_low_limit_i,
  input wire logic [15:0] transformer_ratio_i,
  // command from the controlling party
  input wire logic cmd_valid_i, // pulse, command code present
  input wire logic [7:0] cmd_code_i,
  // measurand read request
  input wire logic rd_i, // pulse, read the value named by rd_id_i
  input wire logic [5:0] rd_id_i,
  output logic rd_ready_o, // engine idle, a read would be taken now
  output logic rd_err_o, // pulse, identifier not served
  // byte stream of the answer
  output logic [7:0] tx_byte_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  // status view
  output logic [3:0] dataset_sequence_tag_o,
  output logic [15:0] limit_violation_status_o
);

  // ==========================================================
  // state
  // ==========================================================
  // one-hot read engine; a request is taken only while idle
  typedef enum logic [1:0] {
    PMS_IDLE = 2'b01, // waiting for a read
    PMS_SEND = 2'b10 // shifting answer bytes out
  } pms_mode_t;

  typedef struct packed {
    pms_mode_t mode; // read engine state
    logic [15:0] status; // sticky limit flags
    logic [3:0] tag; // dataset sequence tag
    logic [31:0] shreg; // answer bytes, next one on top
    logic [2:0] left; // bytes still to send
    logic err; // unknown identifier pulse
  } pms_st_t;

  pms_st_t st_r;
  pms_st_t st_nxt;
  logic [15:0] viol; // limit violations of the present data set
  logic ack; // acknowledge command seen
  logic [31:0] value; // value of the requested identifier
  logic [2:0] len; // its byte count
  logic [1:0][31:0] e_cnt; // energy counts, consumer then producer
  logic [1:0][31:0] e_ovf; // their overflow counts
  logic [1:0] e_wh; // energy step inputs

  // ==========================================================
  // energy counters
  // ==========================================================
  assign e_wh = {prod_wh_i, cons_wh_i};

  generate
    for (genvar k = 0; k < 2; k++) begin : g_energy
      pms_energy_acc u_acc (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .step_i(e_wh[k]),
        .ratio_i(transformer_ratio_i),
        .count_o(e_cnt[k]),
        .ovf_o(e_ovf[k]),
        .wrap_o()
      );
    end
  endgenerate

  // ==========================================================
  // limit comparison
  // ==========================================================
  // compares against live parameters; a write mid-set takes effect at the next refresh
  always_comb begin
    viol = '0;
    // a phase select drops the sign, so cos phi is re-signed before the compare
    for (int p = 0; p < 3; p++) begin
      viol[pms_pkg::BIT_VLO[p]] = vrms_i[p] < rms_voltage_low_limit_i;
      viol[pms_pkg::BIT_VHI[p]] = vrms_i[p] > rms_voltage_high_limit_i;
      viol[pms_pkg::BIT_IHI[p]] = irms_i[p] > rms_current_high_limit_i;
      viol[pms_pkg::BIT_PFLO[p]] = $signed(pf_i[p]) < power_factor_low_limit_i;
    end
    viol[pms_pkg::BIT_TEMP_HI] = temp_i > temperature_high_limit_i;
    viol[pms_pkg::BIT_FREQ_LO] = freq_i < frequency_low_limit_i;
    // the second temperature flag mirrors the first
    viol[pms_pkg::BIT_TEMP_HI2] = viol[pms_pkg::BIT_TEMP_HI];
  end

  assign ack = cmd_valid_i && (cmd_code_i == pms_pkg::CMD_ACK);

  // ==========================================================
  // measurand lookup
  // ==========================================================
  always_comb begin
    value = '0;
    len = pms_pkg::id_len(rd_id_i);
    unique case (rd_id_i)
      pms_pkg::ID_E_CONS: value = e_cnt[0];
      pms_pkg::ID_E_PROD: value = e_cnt[1];
      pms_pkg::ID_OVF_CONS: value = e_ovf[0];
      pms_pkg::ID_OVF_PROD: value = e_ovf[1];
      pms_pkg::ID_FREQ: value = {16'h0000, freq_i};
      pms_pkg::ID_TEMP: value = {16'h0000, temp_i};
      pms_pkg::ID_STATUS: value = {16'h0000, st_r.status};
      pms_pkg::ID_V_L1: value = vrms_i[0];
      pms_pkg::ID_V_L1 + pms_pkg::ID_PH_STEP: value = vrms_i[1];
      pms_pkg::ID_V_L1 + 6'h10: value = vrms_i[2];
      pms_pkg::ID_I_L1: value = {16'h0000, irms_i[0]};
      pms_pkg::ID_I_L1 + pms_pkg::ID_PH_STEP: value = {16'h0000, irms_i[1]};
      pms_pkg::ID_I_L1 + 6'h10: value = {16'h0000, irms_i[2]};
      pms_pkg::ID_PF_L1: value = {24'h000000, pf_i[0]};
      pms_pkg::ID_PF_L1 + pms_pkg::ID_PH_STEP: value = {24'h000000, pf_i[1]};
      pms_pkg::ID_PF_L1 + 6'h10: value = {24'h000000, pf_i[2]};
      default: value = '0;
    endcase
  end

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    st_nxt = st_r;
    st_nxt.err = 1'b0;
    // acknowledge first, so a violation in the same cycle survives
    if (ack) begin
      st_nxt.status = '0;
    end
    if (refresh_i) begin
      st_nxt.status = st_nxt.status | viol;
      // tag runs 1..15 and skips zero
      st_nxt.tag = (st_r.tag == pms_pkg::TAG_MAX) ? pms_pkg::TAG_MIN
                                                 : st_r.tag + 4'h1;
    end
    unique case (st_r.mode)
      PMS_IDLE: begin
        if (rd_i) begin
          if (len == pms_pkg::LEN_NONE) begin
            st_nxt.err = 1'b1;
          end else begin
            // left-align so the most significant byte leaves first
            st_nxt.shreg = value << (6'(4 - len) * 6'd8);
            st_nxt.left = len;
            st_nxt.mode = PMS_SEND;
          end
        end
      end
      PMS_SEND: begin
        st_nxt.shreg = {st_r.shreg[23:0], 8'h00};
        st_nxt.left = st_r.left - 3'h1;
        if (st_r.left == 3'h1) begin
          st_nxt.mode = PMS_IDLE;
        end
      end
    endcase
  end

  // state register; reset leaves the reset flag standing
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_r.mode <= PMS_IDLE;
      st_r.status <= pms_pkg::STATUS_RST;
      st_r.tag <= pms_pkg::TAG_MIN;
      st_r.shreg <= '0;
      st_r.left <= '0;
      st_r.err <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign rd_ready_o = (st_r.mode == PMS_IDLE);
  assign rd_err_o = st_r.err;
  assign tx_byte_o = st_r.shreg[31:24];
  assign tx_valid_o = (st_r.mode == PMS_SEND);
  assign tx_last_o = (st_r.mode == PMS_SEND) && (st_r.left == 3'h1);
  assign dataset_sequence_tag_o = st_r.tag;
  assign limit_violation_status_o = st_r.status;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_status_read;
    rd_i && rd_ready_o && rd_id_i == pms_pkg::ID_STATUS;
  endsequence

  // energy read: four bytes, then the engine is free again
  sequence s_energy_read;
    rd_i && rd_ready_o && rd_id_i == pms_pkg::ID_E_CONS;
  endsequence

  sequence s_four_bytes;
    (tx_valid_o && !tx_last_o) [*3] ##1 (tx_valid_o && tx_last_o)
      ##1 (!tx_valid_o && rd_ready_o);
  endsequence

  a_status_sticky: assert property (
    (!ack && !refresh_i) |=> limit_violation_status_o == $past(limit_violation_status_o))
    else $error("status changed without refresh or acknowledge");
  a_refresh_no_clear: assert property (
    (refresh_i && !ack) |=> (limit_violation_status_o & $past(limit_violation_status_o))
      == $past(limit_violation_status_o))
    else $error("refresh cleared a status bit");
  a_set_beats_ack: assert property (
    (refresh_i && ack) |=> limit_violation_status_o == $past(viol))
    else $error("acknowledge dropped a new violation");
  a_ack_clears: assert property (
    (ack && !refresh_i) |=> limit_violation_status_o == 16'h0000)
    else $error("acknowledge left bits set");
  a_tag_range: assert property (
    dataset_sequence_tag_o != 4'h0)
    else $error("dataset tag reached zero");
  a_tag_step: assert property (
    refresh_i |=> dataset_sequence_tag_o != $past(dataset_sequence_tag_o))
    else $error("tag did not advance on refresh");
  a_status_order: assert property (
    s_status_read |=> tx_valid_o && tx_byte_o == $past(st_r.status[15:8]) ##1
      tx_last_o && tx_byte_o == $past(st_r.status[7:0], 2))
    else $error("status word not sent high byte first");
  a_bad_id_err: assert property (
    (rd_i && rd_ready_o && pms_pkg::id_len(rd_id_i) == 3'h0) |=> rd_err_o && !tx_valid_o)
    else $error("unknown identifier not refused");
  a_vhi_flag: assert property (
    (refresh_i && vrms_i[0] > rms_voltage_high_limit_i) |=> limit_violation_status_o[2])
    else $error("l1 over-voltage not flagged");
  a_pf_flag: assert property (
    (refresh_i && $signed(pf_i[2]) < power_factor_low_limit_i) |=> limit_violation_status_o[14])
    else $error("l3 power factor not flagged");
  // one phase per limit kind, two for voltage low; the other phases share the same loop
  a_vlo_l2_flag: assert property (
    (refresh_i && vrms_i[1] < rms_voltage_low_limit_i) |=> limit_violation_status_o[0])
    else $error("l2 under-voltage not flagged");
  a_vlo_l1_flag: assert property (
    (refresh_i && vrms_i[0] < rms_voltage_low_limit_i) |=> limit_violation_status_o[15])
    else $error("l1 under-voltage not flagged");
  a_ihi_flag: assert property (
    (refresh_i && irms_i[2] > rms_current_high_limit_i) |=> limit_violation_status_o[11])
    else $error("l3 over-current not flagged");
  a_temp_flag: assert property (
    (refresh_i && temp_i > temperature_high_limit_i) |=> limit_violation_status_o[5]
      && limit_violation_status_o[7])
    else $error("over-temperature not flagged");
  a_freq_flag: assert property (
    (refresh_i && freq_i < frequency_low_limit_i) |=> limit_violation_status_o[6])
    else $error("low frequency not flagged");
  // tag may only move with a new data set
  a_tag_hold: assert property (
    !refresh_i |=> dataset_sequence_tag_o == $past(dataset_sequence_tag_o))
    else $error("tag moved without refresh");
  // first edge after any reset still shows the reset flag
  a_reset_flag: assert property (
    $fell(rst_i) |-> limit_violation_status_o[pms_pkg::BIT_RESET])
    else $error("reset flag missing after reset");
  a_four_byte_send: assert property (
    s_energy_read |=> s_four_bytes)
    else $error("energy value not sent as four bytes");

endmodule : pms_status_map

// ===== dv/pms_head_model.sv
`timescale 1ns/1ps
// ==========================================================
// head module model: issues reads and commands
// ==========================================================
module pms_head_model (
  // clock
  input wire logic clk_sys_i,
  // requests to the meter
  output logic rd_o,
  output logic [5:0] rd_id_o,
  output logic cmd_valid_o,
  output logic [7:0] cmd_code_o,
  // answers from the meter
  input wire logic rd_ready_i,
  input wire logic rd_err_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_valid_i,
  input wire logic tx_last_i
);
  // idle lines at time zero
  initial begin
    rd_o = 1'b0;
    rd_id_o = 6'h00;
    cmd_valid_o = 1'b0;
    cmd_code_o = 8'h00;
  end

  // read one measurand; gap idles first so the model can be slow
  task automatic read_id(input logic [5:0] id, input int gap, output logic [31:0] val,
      output logic [2:0] n, output logic err);
    val = 32'h00000000;
    n = 3'h0;
    err = 1'b0;
    repeat (gap) @(posedge clk_sys_i);
    // request only while the meter is idle
    do begin
      @(posedge clk_sys_i);
      #2;
    end while (rd_ready_i !== 1'b1);
    rd_o = 1'b1;
    rd_id_o = id;
    @(posedge clk_sys_i);
    #2;
    rd_o = 1'b0;
    // released id shows garbage, not the last value
    rd_id_o = ~id;
    // bytes arrive most significant first
    for (int i = 0; i < 8; i++) begin
      if (rd_err_i === 1'b1) begin
        err = 1'b1;
        break;
      end
      if (tx_valid_i === 1'b1) begin
        val = {val[23:0], tx_byte_i};
        n = n + 3'h1;
        if (tx_last_i === 1'b1) break;
      end
      @(posedge clk_sys_i);
      #2;
    end
  endtask : read_id

  // one-cycle command strobe
  task automatic send_cmd(input logic [7:0] code);
    @(posedge clk_sys_i);
    #2;
    cmd_valid_o = 1'b1;
    cmd_code_o = code;
    @(posedge clk_sys_i);
    #2;
    cmd_valid_o = 1'b0;
    cmd_code_o = ~code;
  endtask : send_cmd
endmodule : pms_head_model

// ===== dv/pms_status_map_bench.sv
`timescale 1ns/1ps
// ==========================================================
// bench for the power meter status map
// ==========================================================
module pms_status_map_bench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic refresh_i = 1'b0;
  logic cons_wh_i = 1'b0;
  logic prod_wh_i = 1'b0;
  logic [2:0][31:0] vrms_i;
  logic [2:0][15:0] irms_i;
  logic signed [2:0][7:0] pf_i;
  logic signed [15:0] temp_i;
  logic [15:0] freq_i;
  logic [31:0] vlo_lim, vhi_lim;
  logic [15:0] ihi_lim, flo_lim, ratio;
  logic signed [7:0] pflo_lim;
  logic signed [15:0] thi_lim;
  // partner driven and meter driven nets
  logic rd_i, cmd_valid_i, rd_ready_o, rd_err_o, tx_valid_o, tx_last_o;
  logic [5:0] rd_id_i;
  logic [7:0] cmd_code_i, tx_byte_o;
  logic [3:0] tag_o, tag_exp;
  logic [15:0] stat_o, acc;
  logic [31:0] val;
  logic [2:0] n;
  logic err;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  // expected flags per violation case, in case order
  localparam logic [15:0] MASKS [15] = '{16'h8000, 16'h0001, 16'h0002, 16'h0004,
    16'h0008, 16'h0010, 16'h0200, 16'h0400, 16'h0800, 16'h1000, 16'h2000, 16'h4000,
    16'h00a0, 16'h0040, 16'h001c};

  pms_status_map pms_status_map_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .refresh_i(refresh_i), .vrms_i(vrms_i), .irms_i(irms_i), .pf_i(pf_i), .temp_i(temp_i),
    .freq_i(freq_i), .cons_wh_i(cons_wh_i), .prod_wh_i(prod_wh_i),
    .rms_voltage_low_limit_i(vlo_lim), .rms_voltage_high_limit_i(vhi_lim),
    .rms_current_high_limit_i(ihi_lim), .power_factor_low_limit_i(pflo_lim),
    .temperature_high_limit_i(thi_lim), .frequency_low_limit_i(flo_lim),
    .transformer_ratio_i(ratio), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .rd_i(rd_i), .rd_id_i(rd_id_i), .rd_ready_o(rd_ready_o), .rd_err_o(rd_err_o),
    .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o),
    .dataset_sequence_tag_o(tag_o), .limit_violation_status_o(stat_o));

  pms_head_model pms_head_model_inst (.clk_sys_i(clk_sys_i), .rd_o(rd_i), .rd_id_o(rd_id_i),
    .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i), .rd_ready_i(rd_ready_o),
    .rd_err_i(rd_err_o), .tx_byte_i(tx_byte_o), .tx_valid_i(tx_valid_o),
    .tx_last_i(tx_last_o));

  // 40 mhz clock
  always #12.5 clk_sys_i = ~clk_sys_i;

  // hang guard, the whole run needs well under 2000 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("wrong value at %0t: run timed out", $time);
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  // in-range measurements and limits; no flag should rise from these
  task automatic nominal();
    vrms_i = {3{32'h00038270}};
    irms_i = {3{16'h03e8}};
    pf_i = {3{8'h5a}};
    temp_i = 16'h09c4;
    freq_i = 16'h1388;
    vlo_lim = 32'h00030d40;
    vhi_lim = 32'h0003d090;
    ihi_lim = 16'h1388;
    pflo_lim = 8'h50;
    thi_lim = 16'h1b58;
    flo_lim = 16'h1324;
    ratio = 16'h0003;
  endtask : nominal

  // push one violation case onto the measurement inputs, or in the default case onto the voltage high limit
  task automatic violate(input int k);
    case (k)
      0, 1, 2: vrms_i[k] = 32'h00002710;
      3, 4, 5: vrms_i[k-3] = 32'h00040000;
      6, 7, 8: irms_i[k-6] = 16'h2710;
      // negative cos phi must still count as below a positive limit
      9, 10, 11: pf_i[k-9] = 8'hf6;
      12: temp_i = 16'h2710;
      13: freq_i = 16'h1000;
      // nominal voltage, but the limit itself is lowered
      default: vhi_lim = 32'h00030000;
    endcase
  endtask : violate

  // one data set; tag runs 1..15 then wraps to 1
  task automatic refresh(input logic [15:0] exp);
    @(posedge clk_sys_i);
    #2;
    refresh_i = 1'b1;
    @(posedge clk_sys_i);
    #2;
    refresh_i = 1'b0;
    tag_exp = (tag_exp == 4'hf) ? 4'h1 : tag_exp + 4'h1;
    check({28'h0, tag_o}, {28'h0, tag_exp}, "tag");
    check({16'h0, stat_o}, {16'h0, exp}, "status after refresh");
  endtask : refresh

  task automatic rd(input logic [5:0] id, input logic [31:0] exp, input logic [2:0] len,
      input logic bad, input int gap);
    pms_head_model_inst.read_id(id, gap, val, n, err);
    check({31'h0, err}, {31'h0, bad}, "read error flag");
    check({29'h0, n}, {29'h0, len}, "read length");
    check(val, exp, "read value");
  endtask : rd

  // pulses of a consumer or producer energy line, one idle cycle apart
  task automatic wh(input logic prod, input int cnt);
    repeat (cnt) begin
      @(posedge clk_sys_i);
      #2;
      cons_wh_i = ~prod;
      prod_wh_i = prod;
      @(posedge clk_sys_i);
      #2;
      cons_wh_i = 1'b0;
      prod_wh_i = 1'b0;
    end
  endtask : wh

  // main sequence
  initial begin
    nominal();
    tag_exp = 4'h1;
    repeat (3) @(posedge clk_sys_i);
    #2;
    rst_i = 1'b0;
    check({16'h0, stat_o}, 32'h00000100, "status at reset");
    check({28'h0, tag_o}, 32'h00000001, "tag at reset");
    rd(6'h29, 32'h00000100, 3'h2, 1'b0, 0);
    $display("test reset done");
    pms_head_model_inst.send_cmd(8'h03);
    check({16'h0, stat_o}, 32'h00000100, "status after other code");
    pms_head_model_inst.send_cmd(8'h04);
    check({16'h0, stat_o}, 32'h00000000, "status after ack");
    acc = 16'h0000;
    refresh(acc);
    // each case leaves earlier flags set although their cause is gone
    for (int k = 0; k < 15; k++) begin
      violate(k);
      acc = acc | MASKS[k];
      refresh(acc);
      nominal();
    end
    $display("test limit flags done");
    violate(3);
    fork
      pms_head_model_inst.send_cmd(8'h04);
      refresh(16'h0004);
    join
    nominal();
    rd(6'h29, 32'h00000004, 3'h2, 1'b0, 2);
    $display("test ack collision done");
    wh(1'b0, 7);
    wh(1'b1, 3);
    rd(6'h01, 32'h00000002, 3'h4, 1'b0, 0);
    rd(6'h02, 32'h00000001, 3'h4, 1'b0, 1);
    rd(6'h27, 32'h00000000, 3'h4, 1'b0, 0);
    rd(6'h28, 32'h00000000, 3'h4, 1'b0, 0);
    $display("test energy done");
    rd(6'h12, 32'h00038270, 3'h4, 1'b0, 0);
    rd(6'h1b, 32'h000003e8, 3'h2, 1'b0, 0);
    rd(6'h24, 32'h0000005a, 3'h1, 1'b0, 0);
    rd(6'h0c, 32'h00001388, 3'h2, 1'b0, 0);
    rd(6'h0e, 32'h000009c4, 3'h2, 1'b0, 0);
    // identifiers that are not served answer with an error pulse
    for (int i = 0; i < 5; i++) rd(6'(i * 15), 32'h0, 3'h0, 1'b1, 0);
    $display("test id reads done");
    // reset in mid-run raises the reset flag again
    rst_i = 1'b1;
    @(posedge clk_sys_i);
    #2;
    rst_i = 1'b0;
    check({16'h0, stat_o}, 32'h00000100, "status after second reset");
    rd(6'h01, 32'h00000000, 3'h0 + 3'h4, 1'b0, 0);
    $display("test second reset done");
    complete_run();
  end
endmodule : pms_status_map_bench
